//--- hdl/flash_sec_pkg.sv
package flash_sec_pkg;
   // internal sfr offsets
   localparam logic [7:0]  erase_cmd_addr      = 8'h94;
   localparam logic [7:0]  flash_control_addr  = 8'hb2;
   localparam logic [7:0]  page_addr_addr      = 8'hb7;
   // xram-mapped sfr offsets
   localparam logic [15:0] fuse_setup_addr     = 16'hffd1;
   localparam logic [15:0] fuse_trigger_addr   = 16'hffd2;
   localparam logic [15:0] security_addr       = 16'hffd7;
   // flash_control fields
   localparam int          pwe_bit             = 0;
   localparam int          meen_bit            = 1;
   localparam int          secure_bit          = 6;
   // security_settings fields
   localparam int          fuse_prog_bit       = 7;
   localparam int          sec_pin_bit         = 5;
   localparam int          sec_hi_bit          = 1;
   localparam int          sec_lo_bit          = 0;
   // codes
   localparam logic [7:0]  fuse_setup_code     = 8'h54;
   localparam logic [7:0]  fuse_fire_code      = 8'ha6;
   // reset values
   localparam logic [7:0]  reg_reset           = 8'h00;
   typedef enum logic [1:0] {fuse_idle, fuse_armed, fuse_burning} fuse_state_t;
endpackage : flash_sec_pkg

//--- hdl/fuse_seq_if.sv
interface fuse_seq_if;
   logic       setup_wr;
   logic       trigger_wr;
   logic [7:0] wdata;
   logic       prog_en;
   logic       burning;
   logic       armed;
   modport ctrl (output setup_wr, output trigger_wr, output wdata, output prog_en,
                 input burning, input armed);
   modport seq  (input setup_wr, input trigger_wr, input wdata, input prog_en,
                 output burning, output armed);
endinterface : fuse_seq_if

//--- hdl/fuse_sequencer.sv
module fuse_sequencer
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // control side
   fuse_seq_if.seq  fs
);
   flash_sec_pkg::fuse_state_t state_ff;
   flash_sec_pkg::fuse_state_t nxt_state;

   always_comb
   begin
      nxt_state = state_ff;
      // a fresh setup write re-arms or disarms, except during a burn
      if (fs.setup_wr && state_ff != flash_sec_pkg::fuse_burning)
      begin
         if (fs.wdata == flash_sec_pkg::fuse_setup_code)
            nxt_state = flash_sec_pkg::fuse_armed;
         else
            nxt_state = flash_sec_pkg::fuse_idle;
      end
      if (fs.trigger_wr)
      begin
         if (fs.wdata != flash_sec_pkg::fuse_fire_code)
            nxt_state = flash_sec_pkg::fuse_idle;
         else if (state_ff == flash_sec_pkg::fuse_armed && fs.prog_en)
            nxt_state = flash_sec_pkg::fuse_burning;
      end
      // dropping the programming enable aborts a burn so fuses stay safe
      if (!fs.prog_en && state_ff == flash_sec_pkg::fuse_burning)
         nxt_state = flash_sec_pkg::fuse_idle;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         state_ff <= flash_sec_pkg::fuse_idle;
      else
         state_ff <= nxt_state;
   end

   assign fs.burning = (state_ff == flash_sec_pkg::fuse_burning);
   assign fs.armed   = (state_ff == flash_sec_pkg::fuse_armed);
endmodule : fuse_sequencer

//--- hdl/flash_program_security_ctrl.sv
module flash_program_security_ctrl
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // internal sfr port
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   // xram-mapped sfr port
   input  wire logic [15:0] xsfr_addr,
   input  wire logic        xsfr_wr,
   input  wire logic        xsfr_rd,
   input  wire logic [7:0]  xsfr_wdata,
   output logic      [7:0]  xsfr_rdata,
   // cpu external data move
   input  wire logic        ext_move_wr,
   input  wire logic [15:0] data_pointer,
   input  wire logic [7:0]  ext_move_data,
   input  wire logic        int_enable,
   // external data ram
   output logic             xram_wr,
   output logic      [15:0] xram_addr,
   output logic      [7:0]  xram_wdata,
   // program flash
   output logic             flash_wr,
   output logic      [15:0] flash_addr,
   output logic      [7:0]  flash_wdata,
   output logic             mass_erase_start,
   output logic      [7:0]  flash_page_address,
   // security
   input  wire logic        security_pin,
   output logic             read_protect,
   output logic             fuse_burn,
   output logic      [1:0]  security_setting
);
   logic       pwe_ff;
   logic       nxt_pwe;
   logic       meen_ff;
   logic       nxt_meen;
   logic       secure_ff;
   logic       nxt_secure;
   logic [7:0] erase_ff;
   logic [7:0] nxt_erase;
   logic [7:0] page_ff;
   logic [7:0] nxt_page;
   logic       fprog_ff;
   logic       nxt_fprog;
   logic [1:0] secset_ff;
   logic [1:0] nxt_secset;
   logic [7:0] sfr_rdata_ff;
   logic [7:0] nxt_sfr_rdata;
   logic [7:0] xsfr_rdata_ff;
   logic [7:0] nxt_xsfr_rdata;
   logic       xram_wr_ff;
   logic       flash_wr_ff;
   logic [15:0] move_addr_ff;
   logic [7:0] move_data_ff;
   logic       erase_start_ff;
   logic       nxt_erase_start;
   logic       to_flash;
   logic       wr_fctl;
   logic       wr_erase;

   fuse_seq_if fs ();

   fuse_sequencer u_fuse
   (
      .core_clk (core_clk),
      .nrst     (nrst),
      .fs       (fs)
   );

   assign to_flash = ext_move_wr && pwe_ff;
   assign wr_fctl  = sfr_wr && (sfr_addr == flash_sec_pkg::flash_control_addr);
   assign wr_erase = sfr_wr && (sfr_addr == flash_sec_pkg::erase_cmd_addr);

   assign fs.setup_wr   = xsfr_wr && (xsfr_addr == flash_sec_pkg::fuse_setup_addr);
   assign fs.trigger_wr = xsfr_wr && (xsfr_addr == flash_sec_pkg::fuse_trigger_addr);
   assign fs.wdata      = xsfr_wdata;
   // next value, so a write that clears the enable stops a burn at the same edge
   assign fs.prog_en    = nxt_fprog;

   always_comb
   begin
      nxt_pwe         = pwe_ff;
      nxt_meen        = meen_ff;
      nxt_secure      = secure_ff;
      nxt_erase       = erase_ff;
      nxt_page        = page_ff;
      nxt_fprog       = fprog_ff;
      nxt_secset      = secset_ff;
      nxt_erase_start = 1'b0;
      if (to_flash)
         nxt_pwe = 1'b0;
      // a software write with int_enable low in the same cycle as a flash byte write re-arms for the next byte
      if (wr_fctl && !int_enable)
         nxt_pwe = sfr_wdata[flash_sec_pkg::pwe_bit];
      if (wr_erase)
      begin
         nxt_erase = sfr_wdata;
         // one erase per arming: the enable is consumed by the command
         nxt_erase_start = meen_ff;
         nxt_meen        = 1'b0;
      end
      if (wr_fctl)
      begin
         nxt_meen = sfr_wdata[flash_sec_pkg::meen_bit];
         if (sfr_wdata[flash_sec_pkg::secure_bit])
            nxt_secure = 1'b1;
      end
      if (sfr_wr && sfr_addr == flash_sec_pkg::page_addr_addr)
         nxt_page = sfr_wdata;
      if (xsfr_wr && xsfr_addr == flash_sec_pkg::security_addr)
      begin
         nxt_fprog  = xsfr_wdata[flash_sec_pkg::fuse_prog_bit];
         nxt_secset = xsfr_wdata[flash_sec_pkg::sec_hi_bit:flash_sec_pkg::sec_lo_bit];
      end
   end

   always_comb
   begin
      nxt_sfr_rdata = sfr_rdata_ff;
      if (sfr_rd)
      begin
         // write-only bits read as zero
         case (sfr_addr)
            flash_sec_pkg::erase_cmd_addr:     nxt_sfr_rdata = erase_ff;
            flash_sec_pkg::page_addr_addr:     nxt_sfr_rdata = page_ff;
            flash_sec_pkg::flash_control_addr:
               nxt_sfr_rdata = {1'b0, secure_ff, 5'h00, pwe_ff};
            default:                           nxt_sfr_rdata = 8'h00;
         endcase
      end
      nxt_xsfr_rdata = xsfr_rdata_ff;
      if (xsfr_rd)
      begin
         if (xsfr_addr == flash_sec_pkg::security_addr)
            nxt_xsfr_rdata = {2'h0, security_pin, 3'h0, secset_ff};
         else
            nxt_xsfr_rdata = 8'h00;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pwe_ff         <= 1'b0;
         meen_ff        <= 1'b0;
         secure_ff      <= 1'b0;
         erase_ff       <= flash_sec_pkg::reg_reset;
         page_ff        <= flash_sec_pkg::reg_reset;
         fprog_ff       <= 1'b0;
         secset_ff      <= 2'h0;
         sfr_rdata_ff   <= flash_sec_pkg::reg_reset;
         xsfr_rdata_ff  <= flash_sec_pkg::reg_reset;
         erase_start_ff <= 1'b0;
      end
      else
      begin
         pwe_ff         <= nxt_pwe;
         meen_ff        <= nxt_meen;
         secure_ff      <= nxt_secure;
         erase_ff       <= nxt_erase;
         page_ff        <= nxt_page;
         fprog_ff       <= nxt_fprog;
         secset_ff      <= nxt_secset;
         sfr_rdata_ff   <= nxt_sfr_rdata;
         xsfr_rdata_ff  <= nxt_xsfr_rdata;
         erase_start_ff <= nxt_erase_start;
      end
   end

   // move path: one stage of registers so both targets see steady data
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         xram_wr_ff   <= 1'b0;
         flash_wr_ff  <= 1'b0;
         move_addr_ff <= 16'h0000;
         move_data_ff <= 8'h00;
      end
      else
      begin
         xram_wr_ff   <= ext_move_wr && !pwe_ff;
         flash_wr_ff  <= to_flash;
         if (ext_move_wr)
         begin
            move_addr_ff <= data_pointer;
            move_data_ff <= ext_move_data;
         end
      end
   end

   assign xram_wr            = xram_wr_ff;
   assign xram_addr          = move_addr_ff;
   assign xram_wdata         = move_data_ff;
   assign flash_wr           = flash_wr_ff;
   assign flash_addr         = move_addr_ff;
   assign flash_wdata        = move_data_ff;
   assign mass_erase_start   = erase_start_ff;
   assign flash_page_address = page_ff;
   assign read_protect       = secure_ff;
   assign fuse_burn          = fs.burning;
   assign security_setting   = secset_ff;
   assign sfr_rdata          = sfr_rdata_ff;
   assign xsfr_rdata         = xsfr_rdata_ff;
endmodule : flash_program_security_ctrl

//--- test/flash_sec_properties.sv
module flash_sec_properties
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // register ports
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic [15:0] xsfr_addr,
   input wire logic        xsfr_wr,
   input wire logic        xsfr_rd,
   input wire logic [7:0]  xsfr_wdata,
   input wire logic [7:0]  xsfr_rdata,
   // moves and security
   input wire logic        ext_move_wr,
   input wire logic        int_enable,
   input wire logic        security_pin,
   input wire logic        xram_wr,
   input wire logic        flash_wr,
   input wire logic        mass_erase_start,
   input wire logic        read_protect,
   input wire logic        fuse_burn,
   input wire logic [1:0]  security_setting
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   wire ctl = sfr_wr && sfr_addr == 8'hb2;
   // a control write that really reaches the enable bit
   wire pw  = ctl && !int_enable;
   wire era = sfr_wr && sfr_addr == 8'h94;
   wire fs  = xsfr_wr && xsfr_addr == 16'hffd1;
   wire ft  = xsfr_wr && xsfr_addr == 16'hffd2;
   wire sc  = xsfr_wr && xsfr_addr == 16'hffd7;
   move_route_a:
      assert property (pw ##1 ext_move_wr |=> flash_wr == $past(sfr_wdata[0], 2))
      else $error("move target wrong");
   pwe_consumed_a:
      assert property ((ext_move_wr && !pw) ##1 ext_move_wr |=> xram_wr && !flash_wr)
      else $error("enable not cleared");
   pwe_inhibit_a:
      assert property ((ext_move_wr && !pw) ##1 (ctl && int_enable && sfr_wdata[0])
         ##1 ext_move_wr |=> xram_wr) else $error("inhibited write took");
   erase_fire_a:
      assert property ((ctl && sfr_wdata[1]) ##1 era |=> mass_erase_start)
      else $error("no erase pulse");
   secure_hold_a:
      assert property (read_protect |=> read_protect) else $error("protect dropped");
   secure_set_a:
      assert property (ctl && sfr_wdata[6] |=> read_protect) else $error("protect not set");
   burn_start_a:
      assert property ((fs && xsfr_wdata == 8'h54) ##1 (sc && xsfr_wdata[7])
         ##1 (ft && xsfr_wdata == 8'ha6) |=> fuse_burn) else $error("burn not started");
   burn_cause_a:
      assert property ($rose(fuse_burn) |-> $past(ft && xsfr_wdata == 8'ha6))
      else $error("burn without fire code");
   burn_stop_a:
      assert property (ft && xsfr_wdata != 8'ha6 |=> !fuse_burn) else $error("burn not stopped");
   pin_status_a:
      assert property (xsfr_rd && xsfr_addr == 16'hffd7 |=> xsfr_rdata[5] == $past(security_pin))
      else $error("pin status wrong");
   sec_bits_a:
      assert property (sc |=> security_setting == $past(xsfr_wdata[1:0]))
      else $error("setting bits wrong");
   cover property (flash_wr);
   cover property (mass_erase_start);
   cover property ($rose(fuse_burn));
endmodule : flash_sec_properties

bind flash_program_security_ctrl flash_sec_properties chk (.*);

//--- test/flash_program_security_ctrl_bench.sv
module flash_program_security_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, nrst, sfr_wr, sfr_rd, xsfr_wr, xsfr_rd, ext_move_wr, int_enable;
   logic        security_pin, xram_wr, flash_wr, mass_erase_start, read_protect, fuse_burn;
   logic [1:0]  security_setting;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xsfr_wdata, xsfr_rdata, ext_move_data, v;
   logic [7:0]  xram_wdata, flash_wdata, flash_page_address;
   logic [15:0] xsfr_addr, data_pointer, xram_addr, flash_addr, dp;
   logic [31:0] seed = 32'hf4e0;
   int          err_count, n_checks;

   flash_program_security_ctrl DUT (.*);

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function logic [7:0] sec_exp(input logic p, input logic [7:0] d);
      return {2'b00, p, 3'b000, d[1:0]};
   endfunction : sec_exp

   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one bus cycle; signals stay until the next call so writes can run back to back
   task cyc(input logic s, input logic [7:0] a, input logic [7:0] d, input logic x,
            input logic [15:0] xa, input logic [7:0] xd, input logic m);
      @(posedge core_clk);
      sfr_wr        <= s;
      sfr_addr      <= a;
      sfr_wdata     <= d;
      xsfr_wr       <= x;
      xsfr_addr     <= xa;
      xsfr_wdata    <= xd;
      ext_move_wr   <= m;
      data_pointer  <= 16'(rnd());
      ext_move_data <= seed[15:8];
      #1;
   endtask : cyc

   task rd(input logic x, input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      {sfr_wr, xsfr_wr, ext_move_wr} <= 3'b000;
      sfr_rd    <= !x;
      xsfr_rd   <= x;
      sfr_addr  <= a[7:0];
      xsfr_addr <= a;
      @(posedge core_clk);
      sfr_rd  <= 1'b0;
      xsfr_rd <= 1'b0;
      #1 chk("read data", e, x ? xsfr_rdata : sfr_rdata);
   endtask : rd

   task fire(input logic [7:0] s, input logic e);
      cyc(0, 0, 0, 1, 16'hffd1, 8'h54, 0);
      cyc(0, 0, 0, 1, 16'hffd7, s, 0);
      cyc(0, 0, 0, 1, 16'hffd2, 8'ha6, 0);
      cyc(0, 0, 0, 0, 0, 0, 0);
      chk("fuse_burn", e, fuse_burn);
      chk("security_setting", 2'b11, security_setting);
   endtask : fire

   task stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // the whole run needs under 200 cycles
   initial
   begin
      repeat (3000) @(posedge core_clk);
      err_count++;
      stop_test();
   end

   initial
   begin
      {nrst, sfr_wr, sfr_rd, xsfr_wr, xsfr_rd, ext_move_wr, int_enable, security_pin} = '0;
      {sfr_addr, sfr_wdata, xsfr_addr, xsfr_wdata, data_pointer, ext_move_data} = '0;
      security_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      rd(0, 16'h00b2, 8'h00);
      rd(0, 16'h0094, 8'h00);
      rd(0, 16'h00b7, 8'h00);
      rd(1, 16'hffd7, sec_exp(1'b1, 8'h00));
      rd(1, 16'hffd1, 8'h00);
      rd(0, 16'h0095, 8'h00);
      $display("reset test done");
      cyc(1, 8'hb2, 8'h01, 0, 0, 0, 0);
      cyc(0, 0, 0, 0, 0, 0, 1);
      dp = data_pointer;
      v = ext_move_data;
      cyc(0, 0, 0, 0, 0, 0, 1);
      chk("flash_wr", 1'b1, flash_wr);
      chk("flash_addr", dp, flash_addr);
      chk("flash_wdata", v, flash_wdata);
      dp = data_pointer;
      v = ext_move_data;
      int_enable <= 1'b1;
      cyc(1, 8'hb2, 8'h01, 0, 0, 0, 0);
      chk("xram_wr", 1'b1, xram_wr);
      chk("xram_addr", dp, xram_addr);
      chk("xram_wdata", v, xram_wdata);
      cyc(0, 0, 0, 0, 0, 0, 1);
      cyc(0, 0, 0, 0, 0, 0, 0);
      chk("xram_wr", 1'b1, xram_wr);
      int_enable <= 1'b0;
      rd(0, 16'h00b2, 8'h00);
      $display("move test done");
      v = 8'(rnd());
      cyc(1, 8'hb2, 8'h02, 0, 0, 0, 0);
      cyc(1, 8'h94, v, 0, 0, 0, 0);
      cyc(1, 8'hb7, v, 0, 0, 0, 0);
      chk("mass_erase_start", 1'b1, mass_erase_start);
      cyc(1, 8'h94, ~v, 0, 0, 0, 0);
      cyc(0, 0, 0, 0, 0, 0, 0);
      chk("mass_erase_start", 1'b0, mass_erase_start);
      chk("flash_page_address", v, flash_page_address);
      rd(0, 16'h0094, ~v);
      rd(0, 16'h00b7, v);
      cyc(1, 8'hb2, 8'h40, 0, 0, 0, 0);
      cyc(1, 8'hb2, 8'h00, 0, 0, 0, 0);
      cyc(0, 0, 0, 0, 0, 0, 0);
      chk("read_protect", 1'b1, read_protect);
      rd(0, 16'h00b2, 8'h40);
      nrst <= 1'b0;
      @(posedge core_clk);
      nrst <= 1'b1;
      #1 chk("read_protect", 1'b0, read_protect);
      $display("control test done");
      fire(8'h83, 1'b1);
      cyc(0, 0, 0, 1, 16'hffd7, 8'h03, 0);
      cyc(0, 0, 0, 0, 0, 0, 0);
      chk("fuse_burn", 1'b0, fuse_burn);
      fire(8'h83, 1'b1);
      v = (8'(rnd()) == 8'ha6) ? 8'h00 : seed[7:0];
      cyc(0, 0, 0, 1, 16'hffd2, v, 0);
      cyc(0, 0, 0, 0, 0, 0, 0);
      chk("fuse_burn", 1'b0, fuse_burn);
      cyc(0, 0, 0, 1, 16'hffd2, 8'ha6, 0);
      cyc(0, 0, 0, 0, 0, 0, 0);
      chk("fuse_burn", 1'b0, fuse_burn);
      fire(8'h03, 1'b0);
      $display("fuse test done");
      repeat (8)
      begin
         v = 8'(rnd());
         security_pin <= v[7];
         cyc(0, 0, 0, 1, 16'hffd7, v & 8'h03, 0);
         cyc(0, 0, 0, 0, 0, 0, 0);
         chk("security_setting", v[1:0], security_setting);
         rd(1, 16'hffd7, sec_exp(v[7], v));
      end
      $display("security test done");
      stop_test();
   end
endmodule : flash_program_security_ctrl_bench
